/* pkg/ace_regs.svh */
// constants of the accumulator command executor: opcodes, status, frame layout
// assumes frames of nine bytes from a host or a program sequencer on the same clock
`ifndef ACE_REGS_SVH
`define ACE_REGS_SVH

// instruction codes handled here
`define ACE_INS_ACCU_TO_COORD 8'h27
`define ACE_INS_X_CALC 8'h21
`define ACE_INS_ACCU_TO_AXIS 8'h22
`define ACE_INS_ACCU_TO_GLOBAL 8'h23

// reply status meaning success
`define ACE_STATUS_OK 8'h64

// frame layout: byte index of the checksum, last of nine
`define ACE_FRAME_LAST 4'h8

// global parameter that selects coordinate persistence, and its bank
`define ACE_GP_PERSIST 8'h54
`define ACE_GP_PERSIST_BANK 8'h00

// default target address and table shape
`define ACE_DEV_ADDR 8'h01
`define ACE_COORDS 21
`define ACE_MOTORS 1

`endif

/* pkg/ace_pkg.sv */
// types of the accumulator command executor
// assumes the constants header is included by the modules that need numbers
package ace_pkg;

  // operation selected by the type byte of the x operand calculation
  typedef enum logic [7:0] {
    op_add  = 8'h00,
    op_sub  = 8'h01,
    op_mul  = 8'h02,
    op_div  = 8'h03,
    op_mod  = 8'h04,
    op_and  = 8'h05,
    op_or   = 8'h06,
    op_xor  = 8'h07,
    op_not  = 8'h08,
    op_load = 8'h09,
    op_swap = 8'h0a
  } ace_op_e;

  // top-level sequencing
  typedef enum logic [1:0] {
    st_boot    = 2'b00,
    st_restore = 2'b01,
    st_run     = 2'b10
  } ace_state_e;

  typedef logic [31:0] ace_word_t;

endpackage : ace_pkg

/* rtl/ace_coord_mem.sv */
// coordinate table: one write port, one read port with registered data
// assumes one clock; contents are volatile and undefined until written
`timescale 1ns/1ps
module ace_coord_mem #(
  parameter int DW = 32,
  parameter int DEPTH = 21,
  parameter int AW = 5
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);

  logic [DW-1:0] mem [DEPTH];

  // array carries no reset so it can map onto block memory
  always_ff @(posedge clk_i) begin
    if (we_i && (int'(waddr_i) < DEPTH)) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // read data registered; out-of-range reads give zero
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_o <= '0;
    end else if (int'(raddr_i) < DEPTH) begin
      rdata_o <= mem[raddr_i];
    end else begin
      rdata_o <= '0;
    end
  end

endmodule : ace_coord_mem

/* rtl/ace_top.sv */
// accumulator command executor: frame parser, x operand alu, coordinate and
// parameter stores, non-volatile save and startup restore of coordinates
// assumes frame bytes, program loads and the non-volatile store share clk_i
//
// Notes on behaviour
// - code 39 stores accu into coordinate entry
// - parameter 84 selects non-volatile coordinate copy
// - coordinate zero never saved nor restored
// - direct mode replies status 100 per command
// - code 33 runs x register operation
// - types 0-4 add sub mul div mod
// - types 5-7 and or xor into accu
// - type 8 inverts x register
// - type 9 loads x, 10 swaps
// - code 34 stores accu into axis parameter
// - code 35 stores accu into global parameter
// - standalone feeds accu, direct mode replies only
`timescale 1ns/1ps
`include "ace_regs.svh"
module ace_top #(
  parameter logic [7:0] DEV_ADDR = `ACE_DEV_ADDR,
  parameter int COORDS = `ACE_COORDS,
  parameter int MOTORS = `ACE_MOTORS,
  parameter int AW = $clog2(COORDS * MOTORS + 1)
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic standalone_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_byte_i,
  output logic rx_ready_o,
  output logic cksum_err_o,
  input wire logic accu_ld_i,
  input wire logic [31:0] accu_ld_data_i,
  output logic [31:0] accu_o,
  output logic [31:0] x_o,
  output logic reply_valid_o,
  output logic [7:0] reply_ins_o,
  output logic [7:0] reply_status_o,
  output logic [31:0] reply_value_o,
  output logic ap_wr_o,
  output logic [7:0] ap_num_o,
  output logic [7:0] ap_motor_o,
  output logic [31:0] ap_data_o,
  output logic gp_wr_o,
  output logic [7:0] gp_num_o,
  output logic [7:0] gp_bank_o,
  output logic [31:0] gp_data_o,
  output logic persist_o,
  input wire logic nvm_persist_i,
  output logic nvm_wr_o,
  output logic [7:0] nvm_coord_o,
  output logic [7:0] nvm_motor_o,
  output logic [31:0] nvm_data_o,
  output logic nvm_rd_req_o,
  output logic [7:0] nvm_rd_coord_o,
  output logic [7:0] nvm_rd_motor_o,
  input wire logic nvm_rd_ack_i,
  input wire logic [31:0] nvm_rd_data_i,
  input wire logic [7:0] coord_rd_coord_i,
  input wire logic [7:0] coord_rd_motor_i,
  output logic [31:0] coord_rd_data_o
);

  // flat table index of a motor and coordinate pair
  function automatic logic [AW-1:0] addr_of(input logic [7:0] m, input logic [7:0] c);
    logic [15:0] a;
    a = 16'(m) * 16'(COORDS) + 16'(c);
    return a[AW-1:0];
  endfunction : addr_of

  // x operand alu: returns {accu, x}; division by zero leaves both unchanged
  function automatic logic [63:0] calc(input logic [7:0] op, input logic [31:0] a,
                                       input logic [31:0] x);
    logic [63:0] p;
    logic [31:0] na;
    logic [31:0] nx;
    p = 64'($signed(a)) * 64'($signed(x));
    na = a;
    nx = x;
    case (ace_pkg::ace_op_e'(op))
      ace_pkg::op_add: na = a + x;
      ace_pkg::op_sub: na = a - x;
      ace_pkg::op_mul: na = p[31:0];
      ace_pkg::op_div: na = (x == 32'h0) ? a : 32'($signed(a) / $signed(x));
      ace_pkg::op_mod: na = (x == 32'h0) ? a : 32'($signed(a) % $signed(x));
      ace_pkg::op_and: na = a & x;
      ace_pkg::op_or: na = a | x;
      ace_pkg::op_xor: na = a ^ x;
      ace_pkg::op_not: nx = ~x;
      ace_pkg::op_load: nx = a;
      ace_pkg::op_swap: begin
        na = x;
        nx = a;
      end
      default: na = a;
    endcase
    return {na, nx};
  endfunction : calc

  ace_pkg::ace_state_e state;
  logic [3:0] cnt;
  logic [7:0] sum;
  logic [7:0] f_addr;
  logic [7:0] f_ins;
  logic [7:0] f_type;
  logic [7:0] f_bank;
  logic [31:0] f_val;
  logic exec_go;
  logic [31:0] accu;
  logic [31:0] xreg;
  logic persist;
  logic [7:0] rs_coord;
  logic [7:0] rs_motor;
  logic take;
  logic last_ok;
  logic is_aco;
  logic is_calc;
  logic is_aap;
  logic is_agp;
  logic aco_hit;
  logic mem_we;
  logic [AW-1:0] mem_waddr;
  logic [31:0] mem_wdata;
  logic [63:0] alu;

  // bytes accepted only while running; restore holds the host off
  assign rx_ready_o = (state == ace_pkg::st_run);
  assign take = rx_valid_i && rx_ready_o;
  assign last_ok = take && (cnt == `ACE_FRAME_LAST) && (rx_byte_i == sum)
                   && (f_addr == DEV_ADDR);
  assign is_aco = (f_ins == `ACE_INS_ACCU_TO_COORD);
  assign is_calc = (f_ins == `ACE_INS_X_CALC);
  assign is_aap = (f_ins == `ACE_INS_ACCU_TO_AXIS);
  assign is_agp = (f_ins == `ACE_INS_ACCU_TO_GLOBAL);
  // out-of-range entries are dropped rather than aliased onto another motor
  assign aco_hit = exec_go && is_aco && (int'(f_type) < COORDS) && (int'(f_bank) < MOTORS);
  assign alu = calc(f_type, accu, xreg);
  assign accu_o = accu;
  assign x_o = xreg;
  assign persist_o = persist;

  // byte position and running checksum; no resync, the host keeps framing
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt <= 4'h0;
      sum <= 8'h00;
    end else if (take) begin
      if (cnt == `ACE_FRAME_LAST) begin
        cnt <= 4'h0;
        sum <= 8'h00;
      end else begin
        cnt <= cnt + 4'h1;
        sum <= sum + rx_byte_i;
      end
    end
  end

  // field capture: address, instruction, type, bank, value msb first
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      f_addr <= 8'h00;
      f_ins <= 8'h00;
      f_type <= 8'h00;
      f_bank <= 8'h00;
      f_val <= 32'h0;
    end else if (take) begin
      case (cnt)
        4'h0: f_addr <= rx_byte_i;
        4'h1: f_ins <= rx_byte_i;
        4'h2: f_type <= rx_byte_i;
        4'h3: f_bank <= rx_byte_i;
        4'h4, 4'h5, 4'h6, 4'h7: f_val <= {f_val[23:0], rx_byte_i};
        default: f_val <= f_val;
      endcase
    end
  end

  // execute pulse follows a good last byte; a bad checksum is flagged
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      exec_go <= 1'b0;
      cksum_err_o <= 1'b0;
    end else begin
      exec_go <= last_ok;
      cksum_err_o <= take && (cnt == `ACE_FRAME_LAST) && (rx_byte_i != sum);
    end
  end

  // accumulator and x: an x operand calculation in flight wins over a program load
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      accu <= 32'h0;
      xreg <= 32'h0;
    end else if (exec_go && is_calc) begin
      accu <= alu[63:32];
      xreg <= alu[31:0];
    end else if (accu_ld_i) begin
      accu <= accu_ld_data_i;
    end
  end

  // reply only in direct mode; value field carries nothing
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      reply_valid_o <= 1'b0;
      reply_ins_o <= 8'h00;
      reply_status_o <= 8'h00;
      reply_value_o <= 32'h0;
    end else begin
      reply_valid_o <= exec_go && !standalone_i
                       && (is_aco || is_calc || is_aap || is_agp);
      reply_ins_o <= f_ins;
      reply_status_o <= `ACE_STATUS_OK;
      reply_value_o <= 32'h0;
    end
  end

  // axis parameter store strobe
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ap_wr_o <= 1'b0;
      ap_num_o <= 8'h00;
      ap_motor_o <= 8'h00;
      ap_data_o <= 32'h0;
    end else begin
      ap_wr_o <= exec_go && is_aap;
      ap_num_o <= f_type;
      ap_motor_o <= f_bank;
      ap_data_o <= accu;
    end
  end

  // global parameter store strobe
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      gp_wr_o <= 1'b0;
      gp_num_o <= 8'h00;
      gp_bank_o <= 8'h00;
      gp_data_o <= 32'h0;
    end else begin
      gp_wr_o <= exec_go && is_agp;
      gp_num_o <= f_type;
      gp_bank_o <= f_bank;
      gp_data_o <= accu;
    end
  end

  // persistence setting: stored value caught after reset, then rewritable
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      persist <= 1'b0;
    end else if (state == ace_pkg::st_boot) begin
      persist <= nvm_persist_i;
    end else if (exec_go && is_agp && (f_type == `ACE_GP_PERSIST)
                 && (f_bank == `ACE_GP_PERSIST_BANK)) begin
      persist <= (accu != 32'h0);
    end
  end

  // non-volatile copy of a coordinate store, never entry zero
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      nvm_wr_o <= 1'b0;
      nvm_coord_o <= 8'h00;
      nvm_motor_o <= 8'h00;
      nvm_data_o <= 32'h0;
    end else begin
      nvm_wr_o <= aco_hit && persist && (f_type != 8'h00);
      nvm_coord_o <= f_type;
      nvm_motor_o <= f_bank;
      nvm_data_o <= accu;
    end
  end

  // sequencer: boot, restore entries 1..COORDS-1 of every motor, then run
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state <= ace_pkg::st_boot;
      rs_coord <= 8'h01;
      rs_motor <= 8'h00;
    end else begin
      case (state)
        ace_pkg::st_boot: state <= nvm_persist_i ? ace_pkg::st_restore : ace_pkg::st_run;
        ace_pkg::st_restore: begin
          if (nvm_rd_ack_i) begin
            if (int'(rs_coord) == COORDS - 1) begin
              rs_coord <= 8'h01;
              if (int'(rs_motor) == MOTORS - 1) begin
                state <= ace_pkg::st_run;
              end else begin
                rs_motor <= rs_motor + 8'h01;
              end
            end else begin
              rs_coord <= rs_coord + 8'h01;
            end
          end
        end
        ace_pkg::st_run: state <= ace_pkg::st_run;
        default: state <= ace_pkg::st_boot;
      endcase
    end
  end

  assign nvm_rd_req_o = (state == ace_pkg::st_restore);
  assign nvm_rd_coord_o = rs_coord;
  assign nvm_rd_motor_o = rs_motor;

  // table write port: restore data, or accu on a coordinate store
  always_comb begin
    if (nvm_rd_req_o) begin
      mem_we = nvm_rd_ack_i;
      mem_waddr = addr_of(rs_motor, rs_coord);
      mem_wdata = nvm_rd_data_i;
    end else begin
      mem_we = aco_hit;
      mem_waddr = addr_of(f_bank, f_type);
      mem_wdata = accu;
    end
  end

  ace_coord_mem #(
    .DW(32),
    .DEPTH(COORDS * MOTORS),
    .AW(AW)
  ) u_mem (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .we_i(mem_we),
    .waddr_i(mem_waddr),
    .wdata_i(mem_wdata),
    .raddr_i(addr_of(coord_rd_motor_i, coord_rd_coord_i)),
    .rdata_o(coord_rd_data_o)
  );

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  sequence s_good_last;
    last_ok;
  endsequence
  sequence s_calc_op(logic [7:0] t);
    exec_go && is_calc && (f_type == t);
  endsequence

  chk_frame_accept: assert property (s_good_last |=> exec_go)
    else $error("good frame not executed");
  chk_frame_reject: assert property (take && (cnt == `ACE_FRAME_LAST)
    && (rx_byte_i != sum) |=> !exec_go && cksum_err_o)
    else $error("bad checksum executed");
  chk_coord_write: assert property (aco_hit |-> mem_we && mem_wdata == accu)
    else $error("coordinate store missed");
  chk_coord_stored: assert property (aco_hit
    |=> u_mem.mem[$past(mem_waddr)] == $past(accu))
    else $error("coordinate entry not holding accu");
  chk_nvm_follow: assert property (aco_hit && (f_type != 8'h00)
    |=> nvm_wr_o == $past(persist))
    else $error("non-volatile copy wrong");
  chk_nvm_no_zero: assert property (nvm_wr_o |-> nvm_coord_o != 8'h00)
    else $error("entry zero saved");
  chk_restore_zero: assert property (nvm_rd_req_o |-> nvm_rd_coord_o != 8'h00)
    else $error("entry zero restored");
  chk_reply_ok: assert property (exec_go && is_calc && !standalone_i
    |=> reply_valid_o && reply_status_o == `ACE_STATUS_OK)
    else $error("no ok reply");
  chk_standalone_quiet: assert property (standalone_i |=> !reply_valid_o)
    else $error("reply in standalone");
  chk_calc_add: assert property (s_calc_op(8'h00)
    |=> accu == $past(accu) + $past(xreg))
    else $error("add wrong");
  chk_calc_mul: assert property (s_calc_op(8'h02)
    |=> accu == $past(accu) * $past(xreg))
    else $error("mul wrong");
  chk_calc_xor: assert property (s_calc_op(8'h07)
    |=> accu == ($past(accu) ^ $past(xreg)) && $stable(xreg))
    else $error("xor wrong");
  chk_calc_not: assert property (s_calc_op(8'h08)
    |=> xreg == ~$past(xreg) && $stable(accu))
    else $error("not wrong");
  chk_calc_swap: assert property (s_calc_op(8'h0a)
    |=> accu == $past(xreg) && xreg == $past(accu))
    else $error("swap wrong");
  chk_axis_store: assert property (exec_go && is_aap
    |=> ap_wr_o && ap_data_o == $past(accu) && ap_num_o == $past(f_type))
    else $error("axis store wrong");
  chk_global_store: assert property (exec_go && is_agp
    |=> gp_wr_o && gp_data_o == $past(accu) && gp_bank_o == $past(f_bank))
    else $error("global store wrong");

endmodule : ace_top

/* dv/ace_host_model.sv */
// host model: sends nine-byte command frames on the rx byte link
// assumes the executor takes a byte on a rising edge with rx_ready high
`timescale 1ns/1ps
`include "ace_regs.svh"
module ace_host_model (
  input wire logic clk_i,
  input wire logic rx_ready_i,
  output logic rx_valid_o,
  output logic [7:0] rx_byte_o
);
  initial begin
    rx_valid_o = 1'b0;
    rx_byte_o = 8'h00;
  end

  // bad corrupts the checksum on purpose; idle byte is inverted so stale data never matches
  task automatic send(input logic [7:0] ins, input logic [7:0] typ, input logic [7:0] bank,
                      input logic [31:0] val, input logic bad);
    logic [7:0] b [9];
    logic [7:0] s;
    b = '{`ACE_DEV_ADDR, ins, typ, bank, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
    s = 8'h00;
    for (int i = 0; i < 8; i++) s = s + b[i];
    b[8] = bad ? s + 8'h01 : s;
    for (int i = 0; i < 9; i++) begin
      @(negedge clk_i);
      rx_valid_o = 1'b1;
      rx_byte_o = b[i];
      do @(posedge clk_i); while (rx_ready_i !== 1'b1);
    end
    @(negedge clk_i);
    rx_valid_o = 1'b0;
    rx_byte_o = ~b[8];
  endtask : send
endmodule : ace_host_model

/* dv/tb_accumulator_command_executor.sv */
// testbench of the accumulator command executor, one task per scenario
// assumes the host model drives frames; the bench answers non-volatile restores
`timescale 1ns/1ps
`include "ace_regs.svh"
module tb_accumulator_command_executor;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic standalone_i = 1'b0;
  logic rx_valid_i, rx_ready_o, cksum_err_o, accu_ld_i = 1'b0;
  logic [7:0] rx_byte_i, reply_ins_o, reply_status_o, ap_num_o, ap_motor_o, gp_num_o, gp_bank_o;
  logic [31:0] accu_ld_data_i = 32'h0, accu_o, x_o, reply_value_o, ap_data_o, gp_data_o;
  logic reply_valid_o, ap_wr_o, gp_wr_o, persist_o, nvm_wr_o, nvm_rd_req_o;
  logic [7:0] nvm_coord_o, nvm_motor_o, nvm_rd_coord_o, nvm_rd_motor_o;
  logic [7:0] coord_rd_coord_i = 8'h00, coord_rd_motor_i = 8'h00;
  logic [31:0] nvm_data_o, coord_rd_data_o;
  logic nvm_persist_i = 1'b0, nvm_rd_ack_i = 1'b0;
  logic [31:0] nvm_rd_data_i = 32'h0;
  int miscompares = 0, n_checks = 0, n_rep, n_ap, n_gp, n_nvm, n_err;
  logic [31:0] exp_a, exp_x;

  ace_top uut (.clk_i(clk_i), .srst_i(srst_i), .standalone_i(standalone_i),
    .rx_valid_i(rx_valid_i), .rx_byte_i(rx_byte_i), .rx_ready_o(rx_ready_o),
    .cksum_err_o(cksum_err_o), .accu_ld_i(accu_ld_i), .accu_ld_data_i(accu_ld_data_i),
    .accu_o(accu_o), .x_o(x_o), .reply_valid_o(reply_valid_o), .reply_ins_o(reply_ins_o),
    .reply_status_o(reply_status_o), .reply_value_o(reply_value_o), .ap_wr_o(ap_wr_o),
    .ap_num_o(ap_num_o), .ap_motor_o(ap_motor_o), .ap_data_o(ap_data_o), .gp_wr_o(gp_wr_o),
    .gp_num_o(gp_num_o), .gp_bank_o(gp_bank_o), .gp_data_o(gp_data_o),
    .persist_o(persist_o), .nvm_persist_i(nvm_persist_i), .nvm_wr_o(nvm_wr_o),
    .nvm_coord_o(nvm_coord_o), .nvm_motor_o(nvm_motor_o), .nvm_data_o(nvm_data_o),
    .nvm_rd_req_o(nvm_rd_req_o), .nvm_rd_coord_o(nvm_rd_coord_o),
    .nvm_rd_motor_o(nvm_rd_motor_o), .nvm_rd_ack_i(nvm_rd_ack_i),
    .nvm_rd_data_i(nvm_rd_data_i),
    .coord_rd_coord_i(coord_rd_coord_i), .coord_rd_motor_i(coord_rd_motor_i),
    .coord_rd_data_o(coord_rd_data_o));

  ace_host_model host (.clk_i(clk_i), .rx_ready_i(rx_ready_o), .rx_valid_o(rx_valid_i),
    .rx_byte_o(rx_byte_i));

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  // pulse counters sampled at the falling edge, where registered outputs have settled
  always @(negedge clk_i) begin
    if (reply_valid_o === 1'b1) n_rep++;
    if (ap_wr_o === 1'b1) n_ap++;
    if (gp_wr_o === 1'b1) n_gp++;
    if (nvm_wr_o === 1'b1) n_nvm++;
    if (cksum_err_o === 1'b1) n_err++;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done

  task automatic load_accu(input logic [31:0] v);
    @(negedge clk_i);
    accu_ld_i = 1'b1;
    accu_ld_data_i = v;
    @(negedge clk_i);
    accu_ld_i = 1'b0;
  endtask : load_accu

  // answer lands two edges after the last byte; four cycles covers it with margin
  task automatic cmd(input logic [7:0] ins, input logic [7:0] typ, input logic [7:0] bank,
                     input logic bad);
    {n_rep, n_ap, n_gp, n_nvm, n_err} = '0;
    host.send(ins, typ, bank, 32'h5a5a5a5a, bad);
    repeat (4) @(negedge clk_i);
  endtask : cmd

  task automatic test_aco(input logic [7:0] c, input logic [31:0] v);
    load_accu(v);
    cmd(`ACE_INS_ACCU_TO_COORD, c, 8'h00, 1'b0);
    chk(n_rep, 1, "reply count");
    chk(reply_ins_o, `ACE_INS_ACCU_TO_COORD, "reply ins");
    chk(reply_status_o, `ACE_STATUS_OK, "reply status");
    chk(n_nvm, 0, "default setting saved");
    coord_rd_coord_i = c;
    repeat (2) @(negedge clk_i);
    chk(coord_rd_data_o, v, "coord entry");
  endtask : test_aco

  // expected result of one x operand operation, signed and truncated
  task automatic calc_exp(input int op, input logic [31:0] a, input logic [31:0] x);
    exp_a = a;
    exp_x = x;
    case (op)
      0: exp_a = a + x;
      1: exp_a = a - x;
      2: exp_a = a * x;
      3: exp_a = $signed(a) / $signed(x);
      4: exp_a = $signed(a) % $signed(x);
      5: exp_a = a & x;
      6: exp_a = a | x;
      7: exp_a = a ^ x;
      8: exp_x = ~x;
      9: exp_x = a;
      default: begin
        exp_a = x;
        exp_x = a;
      end
    endcase
  endtask : calc_exp

  task automatic test_x_operand_calc_cmd();
    for (int op = 0; op <= 10; op++) begin
      load_accu(32'h00000003);
      cmd(`ACE_INS_X_CALC, 8'h09, 8'h00, 1'b0);
      load_accu(32'hfffffff9);
      cmd(`ACE_INS_X_CALC, op[7:0], 8'h00, 1'b0);
      calc_exp(op, 32'hfffffff9, 32'h00000003);
      chk(accu_o, exp_a, "calc accu");
      chk(x_o, exp_x, "calc x");
      chk(reply_status_o, `ACE_STATUS_OK, "calc status");
      chk(n_rep, 1, "calc reply");
    end
    // x cleared, then a division by zero and an undefined type leave both registers alone
    load_accu(32'h00000000);
    cmd(`ACE_INS_X_CALC, 8'h09, 8'h00, 1'b0);
    load_accu(32'h00000005);
    cmd(`ACE_INS_X_CALC, 8'h03, 8'h00, 1'b0);
    chk(accu_o, 32'h00000005, "div by zero");
    cmd(`ACE_INS_X_CALC, 8'h0b, 8'h00, 1'b0);
    chk(accu_o, 32'h00000005, "unknown op accu");
    chk(x_o, 32'h00000000, "unknown op x");
    chk(n_rep, 1, "unknown op reply");
  endtask : test_x_operand_calc_cmd

  task automatic test_params();
    load_accu(32'h12345678);
    cmd(`ACE_INS_ACCU_TO_AXIS, 8'h04, 8'h00, 1'b0);
    chk(n_ap, 1, "axis write");
    chk({ap_num_o, ap_motor_o}, 16'h0400, "axis num");
    chk(ap_data_o, 32'h12345678, "axis data");
    chk(reply_value_o, 32'h0, "reply value");
    load_accu(32'h00000001);
    cmd(`ACE_INS_ACCU_TO_GLOBAL, `ACE_GP_PERSIST, `ACE_GP_PERSIST_BANK, 1'b0);
    chk(n_gp, 1, "global write");
    chk({gp_num_o, gp_bank_o}, {`ACE_GP_PERSIST, `ACE_GP_PERSIST_BANK}, "global num");
    chk(gp_data_o, 32'h00000001, "global data");
    chk(persist_o, 1, "persist on");
  endtask : test_params

  task automatic test_persist();
    load_accu(32'h0badcafe);
    cmd(`ACE_INS_ACCU_TO_COORD, 8'h00, 8'h00, 1'b0);
    chk(n_nvm, 0, "entry zero saved");
    cmd(`ACE_INS_ACCU_TO_COORD, 8'h02, 8'h00, 1'b0);
    chk(n_nvm, 1, "save count");
    chk({nvm_motor_o, nvm_coord_o}, 16'h0002, "save index");
    chk(nvm_data_o, 32'h0badcafe, "save data");
  endtask : test_persist

  // a corrupted frame must not run and a program run must not reply
  task automatic test_refuse();
    cmd(`ACE_INS_ACCU_TO_AXIS, 8'h01, 8'h00, 1'b1);
    chk(n_err, 1, "checksum flag");
    chk(n_rep + n_ap, 0, "bad frame ran");
    load_accu(32'h00000010);
    standalone_i = 1'b1;
    cmd(`ACE_INS_X_CALC, 8'h09, 8'h00, 1'b0);
    chk(n_rep, 0, "standalone reply");
    chk(x_o, 32'h00000010, "standalone x");
    standalone_i = 1'b0;
  endtask : test_refuse

  // mid-run reset with the stored setting on: entries 1..20 come back, entry 0 keeps its value
  task automatic test_restore();
    int n_req;
    int n_busy;
    n_req = 0;
    n_busy = 0;
    nvm_persist_i = 1'b1;
    srst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    srst_i = 1'b0;
    // the store answers every request at once, data tagged with the entry it came from
    for (int i = 0; i < 60 && rx_ready_o !== 1'b1; i++) begin
      if (nvm_rd_req_o === 1'b1) n_req++;
      if (nvm_rd_req_o === 1'b1 && rx_ready_o !== 1'b0) n_busy++;
      nvm_rd_ack_i = nvm_rd_req_o;
      nvm_rd_data_i = 32'h00001000 + 32'(nvm_rd_coord_o);
      @(negedge clk_i);
    end
    nvm_rd_ack_i = 1'b0;
    chk(n_req, `ACE_COORDS - 1, "restore count");
    chk(n_busy, 0, "host taken in restore");
    chk(persist_o, 1'b1, "persist after boot");
    coord_rd_coord_i = 8'h00;
    repeat (2) @(negedge clk_i);
    chk(coord_rd_data_o, 32'h0badcafe, "entry zero kept");
    coord_rd_coord_i = 8'h14;
    repeat (2) @(negedge clk_i);
    chk(coord_rd_data_o, 32'h00001014, "entry restored");
  endtask : test_restore

  initial begin
    repeat (12) @(negedge clk_i);
    srst_i = 1'b0;
    for (int i = 0; i < 50 && rx_ready_o !== 1'b1; i++) @(negedge clk_i);
    test_aco(8'h01, 32'hdeadbeef);
    test_aco(8'h14, 32'h80000001);
    test_x_operand_calc_cmd();
    test_params();
    test_persist();
    test_refuse();
    test_restore();
    test_done();
  end

  // well beyond the few hundred cycles the scenarios need
  initial begin
    #(25 * 20000);
    miscompares++;
    test_done();
  end
endmodule : tb_accumulator_command_executor
